// [dram_pin_iface.sv]
`timescale 1ns/1ps
`include "dram_pins_defines.svh"
module dram_pin_iface #(
   parameter bit WIDE = 1'b1,
   parameter int DQ_W = `WIDE_DQ_W
)(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic cmd_clk,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [`BANK_W-1:0] bank_sel,
   input wire logic chip_sel_n,
   input wire logic write_cmd_n,
   input wire logic refresh_cmd_n,
   input wire logic mirror_select,
   input wire logic [1:0] write_strobe_clk,
   input wire logic [1:0] write_byte_mask,
   input wire logic [DQ_W-1:0] dq_in,
   output logic [DQ_W-1:0] dq_out,
   output logic [DQ_W-1:0] dq_oe,
   output logic [3:0] read_echo_clk,
   output logic [3:0] read_echo_clk_n,
   output logic [1:0] read_valid,
   output logic [23:0] mode_reg
);
   localparam int NG = DQ_W / `GROUP_W;
   localparam int SA = `BANK_W + `WORD_ADDR_W;
   // ==========================================
   // input synchronisers
   // ==========================================
   // mirror, two masks, clock, three command lines, bank and address
   logic [`ADDR_W+`BANK_W+6:0] s1;
   logic [`ADDR_W+`BANK_W+6:0] s2;
   logic [1:0] ws1;
   logic [1:0] ws2;
   logic [1:0] ws_prev;
   logic [DQ_W-1:0] d1;
   logic [DQ_W-1:0] d2;
   logic ck_prev;
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         s1 <= '0;
         s2 <= '0;
         ws1 <= 2'h0;
         ws2 <= 2'h0;
         ws_prev <= 2'h0;
         d1 <= '0;
         d2 <= '0;
         ck_prev <= 1'b0;
      end
      else
      begin
         s1 <= {mirror_select, write_byte_mask, cmd_clk, chip_sel_n,
                write_cmd_n, refresh_cmd_n, bank_sel, addr};
         s2 <= s1;
         ws1 <= write_strobe_clk;
         ws2 <= ws1;
         ws_prev <= ws2;
         d1 <= dq_in;
         d2 <= d1;
         ck_prev <= s2[`ADDR_W+`BANK_W+3];
      end
   end
   logic [`ADDR_W-1:0] a_s;
   logic [`BANK_W-1:0] b_s;
   logic cs_s;
   logic we_s;
   logic ref_s;
   logic ck_s;
   logic [1:0] dm_s;
   logic mf_s;
   assign {mf_s, dm_s, ck_s, cs_s, we_s, ref_s, b_s, a_s} = s2;
   logic ck_rise;
   assign ck_rise = ck_s && !ck_prev;
   // ==========================================
   // mirror and command decode
   // ==========================================
   // mirrored board reverses the address and bank order; static pin
   logic [`ADDR_W-1:0] a_m;
   logic [`BANK_W-1:0] b_m;
   logic we_m;
   logic ref_m;
   always_comb
   begin
      a_m = a_s;
      b_m = b_s;
      we_m = we_s;
      ref_m = ref_s;
      if (mf_s)
      begin
         a_m = {<<{a_s}};
         b_m = {<<{b_s}};
         we_m = ref_s;
         ref_m = we_s;
      end
   end
   dram_pins_pkg::cmd_t next_cmd;
   always_comb
   begin
      next_cmd = dram_pins_pkg::CMD_NOP;
      if (ck_rise && !cs_s)
      begin
         if (!we_m && !ref_m)
            next_cmd = dram_pins_pkg::CMD_MRS;
         else if (!we_m)
            next_cmd = dram_pins_pkg::CMD_WRITE;
         else if (ref_m)
            next_cmd = dram_pins_pkg::CMD_READ;
      end
   end
   logic [`ADDR_W-1:0] a_cap;
   logic [`BANK_W-1:0] b_cap;
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         a_cap <= '0;
         b_cap <= '0;
         mode_reg <= `MODE_RESET;
      end
      else if (ck_rise)
      begin
         a_cap <= a_m;
         b_cap <= b_m;
         if (next_cmd == dram_pins_pkg::CMD_MRS)
            mode_reg <= {b_m, a_m};
      end
   end
   // ==========================================
   // write path
   // ==========================================
   // capture on the first strobe edge after a write command, commit that single beat
   logic [1:0] ws_edge;
   assign ws_edge = ws2 ^ ws_prev;
   logic wr_pend;
   logic [SA-1:0] wr_slot;
   logic [DQ_W-1:0] wr_word;
   logic [DQ_W-1:0] wr_keep;
   logic wr_go;
   logic [DQ_W-1:0] keep_now;
   always_comb
   begin
      keep_now = '0;
      for (int g = 0; g < NG; g++)
      begin
         // even groups on strobe 0 and mask 0, odd on 1
         keep_now[g*`GROUP_W +: `GROUP_W] = {`GROUP_W{!dm_s[g%2]}};
      end
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         wr_pend <= 1'b0;
         wr_slot <= '0;
         wr_word <= '0;
         wr_keep <= '0;
         wr_go <= 1'b0;
      end
      else
      begin
         wr_go <= 1'b0;
         if (next_cmd == dram_pins_pkg::CMD_WRITE)
         begin
            wr_pend <= 1'b1;
            wr_slot <= SA'({b_m, a_m[`WORD_ADDR_W-1:0]});
         end
         else if (wr_pend && (ws_edge != 2'h0))
         begin
            for (int g = 0; g < NG; g++)
            begin
               if (ws_edge[g%2])
               begin
                  wr_word[g*`GROUP_W +: `GROUP_W] <=
                     d2[g*`GROUP_W +: `GROUP_W];
                  wr_keep[g*`GROUP_W +: `GROUP_W] <=
                     keep_now[g*`GROUP_W +: `GROUP_W];
               end
               else
               begin
                  // a group whose strobe did not move keeps its old word
                  wr_keep[g*`GROUP_W +: `GROUP_W] <= '0;
               end
            end
            wr_pend <= 1'b0;
            wr_go <= 1'b1;
         end
      end
   end
   // ==========================================
   // storage and read path
   // ==========================================
   logic [SA-1:0] rd_slot;
   logic [DQ_W-1:0] rd_word;
   bank_store #(
      .WIDTH(DQ_W),
      .DEPTH(1 << SA),
      .AW(SA)
   ) store (
      .ref_clk(ref_clk),
      .wr_en(wr_go),
      .wr_addr(wr_slot),
      .wr_data(wr_word),
      .wr_keep(wr_keep),
      .rd_addr(rd_slot),
      .rd_data(rd_word)
   );
   logic [`READ_LATENCY:0] rd_pipe;
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         rd_pipe <= '0;
         rd_slot <= '0;
      end
      else
      begin
         rd_pipe <= {rd_pipe[`READ_LATENCY-1:0],
                     next_cmd == dram_pins_pkg::CMD_READ};
         if (next_cmd == dram_pins_pkg::CMD_READ)
            rd_slot <= SA'({b_m, a_m[`WORD_ADDR_W-1:0]});
      end
   end
   // buffer holds read words so a late echo edge loses none
   logic buf_valid;
   logic buf_ready;
   logic [DQ_W-1:0] buf_data;
   logic in_ready;
   skid_buffer #(
      .WIDTH(DQ_W)
   ) rd_buf (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .in_valid(rd_pipe[1]),
      .in_ready(in_ready),
      .in_data(rd_word),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data)
   );
   // ==========================================
   // echo clocks and data out
   // ==========================================
   // echo clock toggles every ref_clk; one word is driven per edge
   logic echo;
   logic [1:0] beat;
   logic [DQ_W-1:0] beat_word;
   assign buf_ready = (beat == 2'h0) && !echo;
   // ==========================================
   // burst word hold
   // ==========================================
   // the buffer moves on at the pop, so the word is held here for the beats
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         beat_word <= '0;
      else if (buf_valid && buf_ready)
         beat_word <= buf_data;
   end
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         echo <= 1'b0;
         read_echo_clk <= 4'h0;
         read_echo_clk_n <= 4'hF;
         beat <= 2'h0;
         dq_out <= '0;
         dq_oe <= '0;
         read_valid <= 2'h0;
      end
      else
      begin
         echo <= ~echo;
         read_echo_clk <= WIDE ? {4{~echo}} : {2'h0, {2{~echo}}};
         read_echo_clk_n <= WIDE ? {4{echo}} : {2'h0, {2{echo}}};
         // flag raised with an echo rise, one ref_clk before the first data beat on the following echo fall
         read_valid <= (buf_valid && buf_ready)
                       ? (WIDE ? 2'h3 : 2'h1) : 2'h0;
         if (buf_valid && buf_ready)
            beat <= 2'(`BURST_LEN);
         else if (beat != 2'h0)
         begin
            beat <= beat - 2'h1;
            dq_out <= beat_word;
            dq_oe <= {DQ_W{1'b1}};
         end
         else
            dq_oe <= '0;
      end
   end
endmodule // dram_pin_iface

// [dram_pins_defines.svh]
// constants for the dram pin command and data interface
`ifndef DRAM_PINS_DEFINES_SVH
`define DRAM_PINS_DEFINES_SVH
`define ADDR_W 20
`define BANK_W 4
`define WIDE_DQ_W 36
`define NARROW_DQ_W 18
`define GROUP_W 9
`define NUM_BANKS 16
`define BANK_WORDS 16
`define WORD_ADDR_W 4
`define READ_LATENCY 3
`define BURST_LEN 2
`define MODE_RESET 24'h000000
`endif

// [dram_pins_pkg.sv]
// types for the dram pin command and data interface
package dram_pins_pkg;
   typedef enum logic [3:0]
   {
      CMD_NOP = 4'h1,
      CMD_READ = 4'h2,
      CMD_WRITE = 4'h4,
      CMD_MRS = 4'h8
   } cmd_t;
endpackage

// [bank_store.sv]
// small masked word store for the banks, registered read data
`timescale 1ns/1ps
module bank_store #(
   parameter int WIDTH = 36,
   parameter int DEPTH = 256,
   parameter int AW = 8
)(
   input wire logic ref_clk,
   input wire logic wr_en,
   input wire logic [AW-1:0] wr_addr,
   input wire logic [WIDTH-1:0] wr_data,
   input wire logic [WIDTH-1:0] wr_keep,
   input wire logic [AW-1:0] rd_addr,
   output logic [WIDTH-1:0] rd_data
);
   logic [WIDTH-1:0] mem [DEPTH];
   always_ff @(posedge ref_clk)
   begin
      if (wr_en)
         mem[wr_addr] <= (mem[wr_addr] & ~wr_keep) | (wr_data & wr_keep);
   end
   always_ff @(posedge ref_clk)
   begin
      rd_data <= mem[rd_addr];
   end
endmodule // bank_store

// [skid_buffer.sv]
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module skid_buffer #(
   parameter int WIDTH = 36
)(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   logic [WIDTH-1:0] slot [2];
   logic [1:0] count;
   logic rd_ptr;
   logic wr_ptr;
   logic push;
   logic pop;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign in_ready = (count != 2'h2);
   assign out_valid = (count != 2'h0);
   assign out_data = slot[rd_ptr];
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         count <= 2'h0;
         rd_ptr <= 1'b0;
         wr_ptr <= 1'b0;
      end
      else
      begin
         count <= count + 2'(push) - 2'(pop);
         if (push)
            wr_ptr <= ~wr_ptr;
         if (pop)
            rd_ptr <= ~rd_ptr;
      end
   end
   always_ff @(posedge ref_clk)
   begin
      if (push)
         slot[wr_ptr] <= in_data;
   end
endmodule // skid_buffer

// [dram_pin_iface_chk.sv]
// assertions on the dram pin interface ports
`timescale 1ns/1ps
module dram_pin_iface_chk #(
   parameter bit WIDE = 1'b1,
   parameter int DQ_W = 36
)(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic chip_sel_n,
   input wire logic [DQ_W-1:0] dq_out,
   input wire logic [DQ_W-1:0] dq_oe,
   input wire logic [3:0] read_echo_clk,
   input wire logic [3:0] read_echo_clk_n,
   input wire logic [1:0] read_valid,
   input wire logic [23:0] mode_reg
);
   // ==========================================
   // idle counter: cycles since chip select low
   logic [4:0] idle;
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         idle <= 5'h00;
      else if (!chip_sel_n)
         idle <= 5'h00;
      else if (idle != 5'h1F)
         idle <= idle + 5'h01;
   end
   // ==========================================
   // properties
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   property p_echo_run;
      1'b1 |=> read_echo_clk[1:0] == ~$past(read_echo_clk[1:0]);
   endproperty
   a_echo_run: assert property (p_echo_run)
      else $error("echo clock did not toggle");
   property p_echo_pair;
      read_echo_clk_n[1:0] == ~read_echo_clk[1:0];
   endproperty
   a_echo_pair: assert property (p_echo_pair)
      else $error("echo clock pair not opposite");
   property p_valid_pulse;
      read_valid[0] |=> !read_valid[0];
   endproperty
   a_valid_pulse: assert property (p_valid_pulse)
      else $error("read valid longer than one cycle");
   property p_beats;
      read_valid[0] |=> (&dq_oe[17:0]) [*2];
   endproperty
   a_beats: assert property (p_beats)
      else $error("data not driven after read valid");
   property p_beat_hold;
      read_valid[0] |=> ##1 $stable(dq_out);
   endproperty
   a_beat_hold: assert property (p_beat_hold)
      else $error("second beat differs");
   property p_oe_cause;
      dq_oe[0] |-> $past(read_valid[0]) || $past(read_valid[0], 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("bus driven without read valid");
   property p_valid_wide;
      WIDE |-> read_valid[1] == read_valid[0];
   endproperty
   a_valid_wide: assert property (p_valid_wide)
      else $error("valid halves disagree");
   property p_idle_read;
      idle >= 5'h10 |-> read_valid == 2'h0;
   endproperty
   a_idle_read: assert property (p_idle_read)
      else $error("read valid while deselected");
   property p_idle_mode;
      idle >= 5'h10 |-> $stable(mode_reg);
   endproperty
   a_idle_mode: assert property (p_idle_mode)
      else $error("mode changed while deselected");
   property p_clear;
      disable iff (1'b0) !reset_n |-> !(|dq_oe) && read_valid == 2'h0;
   endproperty
   a_clear: assert property (p_clear)
      else $error("outputs active in reset");
endmodule // dram_pin_iface_chk
bind dram_pin_iface dram_pin_iface_chk #(.WIDE(WIDE), .DQ_W(DQ_W)) i_chk (
   .ref_clk(ref_clk), .reset_n(reset_n), .chip_sel_n(chip_sel_n),
   .dq_out(dq_out), .dq_oe(dq_oe), .read_echo_clk(read_echo_clk),
   .read_echo_clk_n(read_echo_clk_n), .read_valid(read_valid),
   .mode_reg(mode_reg));

// [ctrl_clock_model.sv]
// controller side clocks: command clock and write strobes
`timescale 1ns/1ps
module ctrl_clock_model (
   output logic cmd_clk,
   output logic [1:0] write_strobe_clk
);
   // ==========================================
   // free-running clocks; cmd_clk edges fall on ref_clk falling edges, strobes unrelated in phase to ref_clk
   initial
   begin
      cmd_clk = 1'b0;
      forever #100 cmd_clk = ~cmd_clk;
   end
   // strobes never stop, even with no write pending
   initial
   begin
      write_strobe_clk = 2'h0;
      #37;
      forever #60 write_strobe_clk = ~write_strobe_clk;
   end
endmodule // ctrl_clock_model

// [dram_pin_iface_tb_top.sv]
// self-checking bench for the dram pin interface
`timescale 1ns/1ps
module dram_pin_iface_tb_top;
   localparam logic [35:0] M0 = 36'h007FC01FF;
   localparam logic [35:0] M1 = 36'hFF803FE00;
   localparam logic [35:0] E3 = (36'h123456789 & M0) | (36'hAAAAAAAAA & M1);
   localparam logic [35:0] E4 = (E3 & M1) | (36'h555555555 & M0);
   typedef struct {logic [3:0] b; logic [19:0] a; logic [35:0] d;
      logic [1:0] m; logic [35:0] e;} row_t;
   row_t rows[6] = '{'{4'h0, 20'h00005, 36'h123456789, 2'h0, 36'h123456789},
      '{4'hF, 20'h00005, 36'hFEDCBA987, 2'h0, 36'hFEDCBA987},
      '{4'h0, 20'h0000A, 36'h0F0F0F0F0, 2'h0, 36'h0F0F0F0F0},
      '{4'h0, 20'h00005, 36'hAAAAAAAAA, 2'h1, E3},
      '{4'h0, 20'h00005, 36'h555555555, 2'h2, E4},
      '{4'h0, 20'h00005, 36'h000000000, 2'h3, E4}};
   logic ref_clk, reset_n, cmd_clk, chip_sel_n, write_cmd_n, refresh_cmd_n;
   logic mirror_select;
   logic [19:0] addr;
   logic [3:0] bank_sel, read_echo_clk, read_echo_clk_n;
   logic [1:0] write_strobe_clk, write_byte_mask, read_valid;
   logic [35:0] dq_in, dq_out, dq_oe;
   logic [23:0] mode_reg;
   int n_mismatch = 0;
   int check_count = 0;
   int cyc = 0;
   // ==========================================
   // instances
   ctrl_clock_model i_ctrl_clock_model (.cmd_clk(cmd_clk),
      .write_strobe_clk(write_strobe_clk));
   dram_pin_iface #(.WIDE(1'b1), .DQ_W(36)) i_dram_pin_iface (
      .ref_clk(ref_clk), .reset_n(reset_n), .cmd_clk(cmd_clk), .addr(addr),
      .bank_sel(bank_sel), .chip_sel_n(chip_sel_n), .write_cmd_n(write_cmd_n),
      .refresh_cmd_n(refresh_cmd_n), .mirror_select(mirror_select),
      .write_strobe_clk(write_strobe_clk), .write_byte_mask(write_byte_mask),
      .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
      .read_echo_clk(read_echo_clk), .read_echo_clk_n(read_echo_clk_n),
      .read_valid(read_valid), .mode_reg(mode_reg));
   // ==========================================
   // tasks
   task automatic chk(input logic [35:0] got, input logic [35:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // fields held four cycles past the command clock rise, then deselect
   task automatic cmd(input logic cs, we, rf, input logic [3:0] b,
      input logic [19:0] a);
      @(posedge ref_clk);
      chip_sel_n <= cs;
      write_cmd_n <= we;
      refresh_cmd_n <= rf;
      bank_sel <= b;
      addr <= a;
      @(posedge cmd_clk);
      repeat (4) @(posedge ref_clk);
      chip_sel_n <= 1'b1;
   endtask
   task automatic wr(input logic cs, input logic [3:0] b, input logic [19:0] a,
      input logic [35:0] d, input logic [1:0] m);
      @(posedge ref_clk);
      dq_in <= d;
      write_byte_mask <= m;
      cmd(cs, 1'b0, 1'b1, b, a);
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic rd(input logic [3:0] b, input logic [19:0] a,
      input logic [35:0] e);
      int i;
      i = 0;
      cmd(1'b0, 1'b1, 1'b1, b, a);
      @(negedge ref_clk);
      while (read_valid[0] !== 1'b1 && i < 40)
      begin
         @(negedge ref_clk);
         i++;
      end
      chk({35'h0, read_valid[0]}, 36'h1);
      @(negedge ref_clk);
      chk(dq_out, e);
      chk(dq_oe, 36'hFFFFFFFFF);
      @(negedge ref_clk);
      chk(dq_out, e);
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_mismatch);
      if (n_mismatch == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // ==========================================
   // clock and timeout
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         tally_and_finish();
      end
   end
   // ==========================================
   // main sequence
   initial
   begin
      logic [19:0] ra;
      reset_n = 1'b0;
      chip_sel_n = 1'b1;
      write_cmd_n = 1'b1;
      refresh_cmd_n = 1'b1;
      mirror_select = 1'b0;
      addr = 20'h00000;
      bank_sel = 4'h0;
      write_byte_mask = 2'h0;
      dq_in = 36'h000000000;
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      foreach (rows[i])
      begin
         wr(1'b0, rows[i].b, rows[i].a, rows[i].d, rows[i].m);
         rd(rows[i].b, rows[i].a, rows[i].e);
         $display("row %0d done", i);
      end
      wr(1'b1, 4'h0, 20'h00005, 36'h0BADBAD00, 2'h0);
      rd(4'h0, 20'h00005, E4);
      cmd(1'b0, 1'b0, 1'b0, 4'hA, 20'h12345);
      repeat (8) @(negedge ref_clk);
      chk({12'h000, mode_reg}, 36'h0A12345);
      cmd(1'b0, 1'b1, 1'b0, 4'h3, 20'hFFFFF);
      repeat (8) @(negedge ref_clk);
      chk({12'h000, mode_reg}, 36'h0A12345);
      $display("mode and refresh done");
      ra = {<<{20'h00009}};
      mirror_select <= 1'b1;
      // mirrored layout swaps the write and refresh lines on the pins
      @(posedge ref_clk);
      dq_in <= 36'h3C3C3C3C3;
      write_byte_mask <= 2'h0;
      cmd(1'b0, 1'b1, 1'b0, 4'hC, ra);
      repeat (8) @(posedge ref_clk);
      mirror_select <= 1'b0;
      rd(4'h3, 20'h00009, 36'h3C3C3C3C3);
      $display("mirror done");
      @(posedge ref_clk);
      reset_n <= 1'b0;
      #2;
      chk({12'h000, mode_reg}, 36'h0);
      chk(dq_oe, 36'h0);
      chk({28'h0, read_echo_clk, read_echo_clk_n}, 36'h0F);
      repeat (4) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (24) @(posedge ref_clk);
      $display("reset done");
      tally_and_finish();
   end
endmodule // dram_pin_iface_tb_top
